// ==== hw/serial_nvm_write_sequencer.sv ====
// Serial programming port with code block and data byte write paths
//
// Behaviour
// [R1] Frames are a 4-bit command and 16-bit payload; 0000 runs a core op.
// [R2] The command arrives least significant bit first on the serial clock.
// [R3] Programmer starts block erase by setting write start, then a no-op.
// [R4] Table pointer picks which write buffer bytes take the payload.
// [R5] Command 1101 stores two bytes and advances the pointer by two.
// [R6] Command 1111 stores two bytes and starts block programming.
// [R7] Programmer loops read, erase and load over the whole block.
// [R8] Programmer clears write allow when modification is done.
// [R9] Data memory is written bytewise via address pair and data latch.
// [R10] A data byte write erases the location first, then programs.
// [R11] Code and config selects must both be zero for a data write.
// [R12] Writes are ignored unless write allow is set.
// [R13] Setting write start begins the data write sequence.
// [R14] The write begins on the fourth serial clock fall after start.
// [R15] Hardware clears write start when the write completes.
// [R16] Programmer holds the serial clock low for discharge after writes.
// [R17] Programmer loads the address pair with core store instructions.
// [R18] Programmer loads the data latch with a core store instruction.
// [R19] Control copied to holding latch, shifted out by command 0010.
// [R20] While writing, write start stays set and new starts are ignored.
`timescale 1ns/1ns
module serial_nvm_write_sequencer
    import nvm_prog_pkg::*;
#(
    parameter int BUF_BYTES = WRITE_BUFFER_BYTES,
    parameter int ERASE_COUNT = ERASE_CYCLES,
    parameter int PROGRAM_COUNT = PROGRAM_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic prog_serial_clock,
    input wire logic prog_serial_line_in,
    output logic prog_serial_line_out,
    output logic prog_serial_line_oe,
    output logic [POINTER_BITS-1:0] nv_addr,
    output logic [7:0] nv_byte,
    output logic [BUF_BYTES*8-1:0] nv_block,
    output logic nv_code_space,
    output logic nv_erase_en,
    output logic nv_program_en,
    output logic write_busy
);
    localparam int IDX_W = $clog2(BUF_BYTES);

    // Link domain state, all on the falling serial clock edge
    logic [4:0] bit_cnt_reg;
    logic [FRAME_BITS-1:0] shift_reg;
    logic [3:0] cmd_reg;
    logic [7:0] out_shift_reg;
    logic out_en_reg;
    logic [7:0] accum_reg;
    logic [7:0] addr_low_reg;
    logic [7:0] addr_high_reg;
    logic [7:0] data_latch_reg;
    logic [7:0] hold_reg;
    logic [POINTER_BITS-1:0] ptr_reg;
    logic [7:0] buf_reg [BUF_BYTES];
    logic code_space_reg;
    logic config_space_reg;
    logic erase_row_reg;
    logic allow_reg;
    logic wr_reg;
    write_mode_t mode_reg;
    logic pending_reg;
    logic [2:0] fall_cnt_reg;
    logic start_tgl_reg;
    logic done_seen_reg;
    write_mode_t launch_mode_reg;
    logic [POINTER_BITS-1:0] launch_addr_reg;
    logic [7:0] launch_data_reg;
    logic [BUF_BYTES*8-1:0] launch_block_reg;
    // Sys domain state; done_sync is synchronised on the serial clock
    engine_state_t state_reg;
    logic [15:0] cnt_reg;
    logic start_seen_reg;
    logic done_tgl_reg;
    logic start_sync;
    logic done_sync;

    function automatic logic [7:0] pack_control(
        input logic code, input logic cfg, input logic erow,
        input logic allow, input logic wr);
        logic [7:0] v;
        v = CONTROL_RESET;
        v[BIT_CODE_SPACE] = code;
        v[BIT_CONFIG_SPACE] = cfg;
        v[BIT_ERASE_ROW] = erow;
        v[BIT_WRITE_ALLOW] = allow;
        v[BIT_WRITE_START] = wr;
        return v;
    endfunction : pack_control

    // Frame decode
    wire [FRAME_BITS-1:0] frame_word = {prog_serial_line_in,
                                        shift_reg[FRAME_BITS-1:1]};
    wire frame_done = (bit_cnt_reg == FRAME_LAST);
    wire [3:0] cmd_now = frame_word[3:0];
    wire [7:0] op_hi = frame_word[19:12];
    wire [7:0] op_lo = frame_word[11:4];
    wire is_core = frame_done && (cmd_now == CMD_CORE); // [R1]
    wire ins_literal = is_core && (op_hi == OP_LOAD_LITERAL);
    wire ins_store = is_core && (op_hi == OP_STORE_ACCUM);
    wire ins_load = is_core && (op_hi == OP_LOAD_FILE) &&
                    (op_lo == FILE_CONTROL);
    wire bit_set = (op_hi[7:4] == OP_SET_BIT);
    wire ins_bit = is_core && (op_lo == FILE_CONTROL) &&
                   (bit_set || (op_hi[7:4] == OP_CLEAR_BIT));
    wire [2:0] bit_pos = op_hi[3:1];
    wire [7:0] control_read = pack_control(code_space_reg,
        config_space_reg, erase_row_reg, allow_reg, wr_reg);

    wire st_ctrl = ins_store && (op_lo == FILE_CONTROL);
    wire st_data = ins_store && (op_lo == FILE_DATA);
    wire st_alow = ins_store && (op_lo == FILE_ADDR_LOW);
    wire st_ahigh = ins_store && (op_lo == FILE_ADDR_HIGH);
    wire st_hold = ins_store && (op_lo == FILE_HOLD);
    wire st_plow = ins_store && (op_lo == FILE_PTR_LOW);
    wire st_phigh = ins_store && (op_lo == FILE_PTR_HIGH);
    wire st_pup = ins_store && (op_lo == FILE_PTR_UPPER);

    function automatic logic next_bit(input logic cur,
                                      input logic [2:0] pos);
        logic v;
        v = cur;
        if (st_ctrl)
            v = accum_reg[pos];
        if (ins_bit && (bit_pos == pos))
            v = bit_set;
        return v;
    endfunction : next_bit

    // Write start decisions
    wire tbl_inc = frame_done && (cmd_now == CMD_WRITE_INC2);
    wire tbl_start = frame_done && (cmd_now == CMD_WRITE_START);
    wire ee_ok = !code_space_reg && !config_space_reg; // [R11]
    wire erase_ok = code_space_reg && !config_space_reg && erase_row_reg;
    wire set_wr_req = ins_bit && bit_set && (bit_pos == BIT_WRITE_START);
    wire core_start = set_wr_req && allow_reg && !wr_reg && // [R12] [R20]
                      (ee_ok || erase_ok); // [R13]
    wire block_start = tbl_start && allow_reg && !wr_reg && // [R6] [R12]
                       !config_space_reg;
    wire start_now = core_start || block_start;
    wire launch_now = pending_reg && (fall_cnt_reg == START_FALLS - 3'h1);
    wire done_event = (done_sync != done_seen_reg);
    wire [IDX_W-1:0] buf_idx = {ptr_reg[IDX_W-1:1], 1'b0}; // [R4]
    wire [POINTER_BITS-1:0] block_base = {ptr_reg[POINTER_BITS-1:IDX_W],
                                          {IDX_W{1'b0}}};
    wire [POINTER_BITS-1:0] ptr_next =
        st_plow ? {ptr_reg[21:8], accum_reg} :
        st_phigh ? {ptr_reg[21:16], accum_reg, ptr_reg[7:0]} :
        st_pup ? {accum_reg[5:0], ptr_reg[15:0]} :
        tbl_inc ? ptr_reg + POINTER_STEP : ptr_reg; // [R5]
    wire [BUF_BYTES*8-1:0] buf_flat;

    genvar gi;
    generate
        for (gi = 0; gi < BUF_BYTES; gi++)
        begin : g_flat
            assign buf_flat[gi*8 +: 8] = buf_reg[gi];
        end
    endgenerate

    // Serial shift and command capture, LSB first
    always_ff @(negedge prog_serial_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt_reg <= 5'h00;
            shift_reg <= '0;
            cmd_reg <= CMD_CORE;
        end
        else
        begin
            bit_cnt_reg <= frame_done ? 5'h00 : bit_cnt_reg + 5'h01; // [R1]
            shift_reg <= frame_word;
            if (bit_cnt_reg == CMD_LAST)
                cmd_reg <= frame_word[19:16]; // [R2]
        end
    end

    // Holding latch drives the line in the last eight payload clocks
    always_ff @(negedge prog_serial_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_shift_reg <= 8'h00;
            out_en_reg <= 1'b0;
        end
        else if (bit_cnt_reg == OUT_LOAD_BIT)
        begin
            out_shift_reg <= hold_reg; // [R19]
            out_en_reg <= (cmd_reg == CMD_SHIFT_OUT);
        end
        else if (frame_done)
            out_en_reg <= 1'b0;
        else
            out_shift_reg <= {1'b0, out_shift_reg[7:1]};
    end

    // Core-reachable files
    always_ff @(negedge prog_serial_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            accum_reg <= 8'h00;
            addr_low_reg <= 8'h00;
            addr_high_reg <= 8'h00;
            data_latch_reg <= 8'h00;
            hold_reg <= 8'h00;
            ptr_reg <= '0;
        end
        else
        begin
            if (ins_literal)
                accum_reg <= op_lo;
            else if (ins_load)
                accum_reg <= control_read; // [R19]
            if (st_alow)
                addr_low_reg <= accum_reg; // [R9] [R17]
            if (st_ahigh)
                addr_high_reg <= accum_reg; // [R9] [R17]
            if (st_data)
                data_latch_reg <= accum_reg; // [R9] [R18]
            if (st_hold)
                hold_reg <= accum_reg; // [R19]
            ptr_reg <= ptr_next;
        end
    end

    // Write buffer, two bytes per table write
    always_ff @(negedge prog_serial_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < BUF_BYTES; i++)
                buf_reg[i] <= 8'hff;
        end
        else if (tbl_inc || tbl_start)
        begin
            buf_reg[buf_idx] <= frame_word[11:4]; // [R4] [R5] [R6]
            buf_reg[buf_idx + 1'b1] <= frame_word[19:12];
        end
    end

    // Control register fields
    always_ff @(negedge prog_serial_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code_space_reg <= CONTROL_RESET[BIT_CODE_SPACE];
            config_space_reg <= CONTROL_RESET[BIT_CONFIG_SPACE];
            erase_row_reg <= CONTROL_RESET[BIT_ERASE_ROW];
            allow_reg <= CONTROL_RESET[BIT_WRITE_ALLOW];
            mode_reg <= MODE_EE_BYTE;
        end
        else
        begin
            code_space_reg <= next_bit(code_space_reg, BIT_CODE_SPACE);
            config_space_reg <= next_bit(config_space_reg,
                                         BIT_CONFIG_SPACE); // [R11]
            erase_row_reg <= next_bit(erase_row_reg, BIT_ERASE_ROW);
            allow_reg <= next_bit(allow_reg, BIT_WRITE_ALLOW); // [R12]
            if (start_now)
                mode_reg <= block_start ? MODE_BLOCK_PROGRAM :
                            (ee_ok ? MODE_EE_BYTE : MODE_BLOCK_ERASE);
        end
    end

    // Write start bit: software sets, only completion clears
    always_ff @(negedge prog_serial_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_reg <= CONTROL_RESET[BIT_WRITE_START];
            done_seen_reg <= 1'b0;
        end
        else
        begin
            done_seen_reg <= done_sync;
            if (done_event)
                wr_reg <= 1'b0; // [R15]
            else if (start_now)
                wr_reg <= 1'b1; // [R13] [R20]
        end
    end

    // Count serial clock falls before launching the array cycle
    always_ff @(negedge prog_serial_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_reg <= 1'b0;
            fall_cnt_reg <= 3'h0;
            start_tgl_reg <= 1'b0;
        end
        else if (start_now)
        begin
            pending_reg <= 1'b1;
            fall_cnt_reg <= 3'h0;
        end
        else if (launch_now)
        begin
            pending_reg <= 1'b0;
            start_tgl_reg <= ~start_tgl_reg; // [R14]
        end
        else if (pending_reg)
            fall_cnt_reg <= fall_cnt_reg + 3'h1;
    end

    // Launch words stay still until the done toggle returns
    always_ff @(negedge prog_serial_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            launch_mode_reg <= MODE_EE_BYTE;
            launch_addr_reg <= '0;
            launch_data_reg <= 8'h00;
            launch_block_reg <= '0;
        end
        else if (launch_now)
        begin
            launch_mode_reg <= mode_reg;
            launch_addr_reg <= (mode_reg == MODE_EE_BYTE) ?
                {6'h00, addr_high_reg, addr_low_reg} : block_base;
            launch_data_reg <= data_latch_reg;
            launch_block_reg <= buf_flat;
        end
    end

    level_sync #(.WIDTH(1)) u_start_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .async_in(start_tgl_reg),
        .sync_out(start_sync)
    );

    level_sync #(.WIDTH(1)) u_done_sync (
        .clk(prog_serial_clock),
        .rst_n(rst_n),
        .async_in(done_tgl_reg),
        .sync_out(done_sync)
    );

    // Array engine on the system clock
    wire start_event = (start_sync != start_seen_reg);
    wire cnt_end_erase = (cnt_reg == 16'(ERASE_COUNT - 1));
    wire cnt_end_prog = (cnt_reg == 16'(PROGRAM_COUNT - 1));

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= 16'h0000;
            start_seen_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
            nv_addr <= '0;
            nv_byte <= 8'h00;
            nv_block <= '0;
            nv_code_space <= 1'b0;
        end
        else
        begin
            start_seen_reg <= start_sync;
            cnt_reg <= cnt_reg + 16'h0001;
            case (state_reg)
                ST_IDLE:
                begin
                    cnt_reg <= 16'h0000;
                    if (start_event)
                    begin
                        nv_addr <= launch_addr_reg;
                        nv_byte <= launch_data_reg;
                        nv_block <= launch_block_reg;
                        nv_code_space <= (launch_mode_reg != MODE_EE_BYTE);
                        state_reg <= (launch_mode_reg == MODE_BLOCK_PROGRAM)
                                     ? ST_PROGRAM : ST_ERASE; // [R10]
                    end
                end
                ST_ERASE:
                    if (cnt_end_erase)
                    begin
                        cnt_reg <= 16'h0000;
                        state_reg <= (nv_code_space &&
                            launch_mode_reg == MODE_BLOCK_ERASE) ?
                            ST_DONE : ST_PROGRAM; // [R10]
                    end
                ST_PROGRAM:
                    if (cnt_end_prog)
                        state_reg <= ST_DONE;
                ST_DONE:
                begin
                    done_tgl_reg <= ~done_tgl_reg; // [R15]
                    state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    assign nv_erase_en = (state_reg == ST_ERASE);
    assign nv_program_en = (state_reg == ST_PROGRAM);
    assign write_busy = (state_reg != ST_IDLE);
    assign prog_serial_line_out = out_shift_reg[0];
    assign prog_serial_line_oe = out_en_reg;

    property p_frame_wrap; // [R1]
        @(negedge prog_serial_clock) disable iff (!rst_n)
        frame_done |=> (bit_cnt_reg == 5'h00);
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) // [R1]
        else $error("frame counter did not wrap after twenty bits");

    property p_cmd_lsb_first; // [R2]
        @(negedge prog_serial_clock) disable iff (!rst_n)
        (bit_cnt_reg == CMD_LAST) |=> (cmd_reg ==
            {$past(prog_serial_line_in), $past(prog_serial_line_in, 2),
             $past(prog_serial_line_in, 3), $past(prog_serial_line_in, 4)});
    endproperty
    a_cmd_lsb_first: assert property (p_cmd_lsb_first) // [R2]
        else $error("command not assembled least significant bit first");

    property p_wr_needs_allow; // [R12]
        @(negedge prog_serial_clock) disable iff (!rst_n)
        $rose(wr_reg) |-> $past(allow_reg);
    endproperty
    a_wr_needs_allow: assert property (p_wr_needs_allow) // [R12]
        else $error("write started without write allow");

    property p_fourth_fall; // [R14]
        @(negedge prog_serial_clock) disable iff (!rst_n)
        $rose(wr_reg) |-> (!launch_now) [*3] ##1 launch_now;
    endproperty
    a_fourth_fall: assert property (p_fourth_fall) // [R14]
        else $error("write not launched on fourth clock fall");

    property p_wr_held; // [R20]
        @(negedge prog_serial_clock) disable iff (!rst_n)
        (wr_reg && !done_event) |=> wr_reg;
    endproperty
    a_wr_held: assert property (p_wr_held) // [R20]
        else $error("write start dropped while write in progress");

    property p_wr_cleared; // [R15]
        @(negedge prog_serial_clock) disable iff (!rst_n)
        done_event |=> !wr_reg;
    endproperty
    a_wr_cleared: assert property (p_wr_cleared) // [R15]
        else $error("write start not cleared on completion");

    property p_ptr_step; // [R5]
        @(negedge prog_serial_clock) disable iff (!rst_n)
        tbl_inc |=> (ptr_reg == $past(ptr_reg) + POINTER_STEP);
    endproperty
    a_ptr_step: assert property (p_ptr_step) // [R5]
        else $error("table pointer did not advance by two");

    property p_ee_space; // [R11]
        @(negedge prog_serial_clock) disable iff (!rst_n)
        ($rose(wr_reg) && mode_reg == MODE_EE_BYTE) |->
            $past(!code_space_reg && !config_space_reg);
    endproperty
    a_ee_space: assert property (p_ee_space) // [R11]
        else $error("data write started with a space select set");

    property p_erase_first; // [R10]
        @(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_IDLE && start_event &&
         launch_mode_reg == MODE_EE_BYTE) |=> (state_reg == ST_ERASE);
    endproperty
    a_erase_first: assert property (p_erase_first) // [R10]
        else $error("data write did not erase first");

    property p_block_start; // [R6]
        @(negedge prog_serial_clock) disable iff (!rst_n)
        block_start |=> (wr_reg && mode_reg == MODE_BLOCK_PROGRAM);
    endproperty
    a_block_start: assert property (p_block_start) // [R6]
        else $error("block programming not started by 1111");
endmodule : serial_nvm_write_sequencer

// ==== hw/nvm_prog_pkg.sv ====
// Shared constants and types of the serial nonvolatile write sequencer
package nvm_prog_pkg;
    // Serial commands, as the 4-bit value after LSB-first reassembly
    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_SHIFT_OUT = 4'h2;
    localparam logic [3:0] CMD_WRITE_INC2 = 4'hd;
    localparam logic [3:0] CMD_WRITE_START = 4'hf;
    localparam int CMD_BITS = 4;
    localparam int PAYLOAD_BITS = 16;
    localparam int FRAME_BITS = CMD_BITS + PAYLOAD_BITS;
    localparam logic [4:0] FRAME_LAST = 5'h13;
    localparam logic [4:0] CMD_LAST = 5'h03;
    // Shift-out drives the line in the last eight payload bits
    localparam logic [4:0] OUT_LOAD_BIT = 5'h0b;
    // Core instruction fields
    localparam logic [7:0] OP_LOAD_LITERAL = 8'h0e;
    localparam logic [7:0] OP_STORE_ACCUM = 8'h6e;
    localparam logic [7:0] OP_LOAD_FILE = 8'h50;
    localparam logic [3:0] OP_SET_BIT = 4'h8;
    localparam logic [3:0] OP_CLEAR_BIT = 4'h9;
    // File addresses reachable by core instructions
    localparam logic [7:0] FILE_CONTROL = 8'ha6;
    localparam logic [7:0] FILE_DATA = 8'ha8;
    localparam logic [7:0] FILE_ADDR_LOW = 8'ha9;
    localparam logic [7:0] FILE_ADDR_HIGH = 8'haa;
    localparam logic [7:0] FILE_HOLD = 8'hf5;
    localparam logic [7:0] FILE_PTR_LOW = 8'hf6;
    localparam logic [7:0] FILE_PTR_HIGH = 8'hf7;
    localparam logic [7:0] FILE_PTR_UPPER = 8'hf8;
    // Control register bit positions and reset value
    localparam logic [2:0] BIT_CODE_SPACE = 3'h7;
    localparam logic [2:0] BIT_CONFIG_SPACE = 3'h6;
    localparam logic [2:0] BIT_ERASE_ROW = 3'h4;
    localparam logic [2:0] BIT_WRITE_ALLOW = 3'h2;
    localparam logic [2:0] BIT_WRITE_START = 3'h1;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int POINTER_BITS = 22;
    localparam logic [21:0] POINTER_STEP = 22'h000002;
    localparam int WRITE_BUFFER_BYTES = 8;
    localparam logic [2:0] START_FALLS = 3'h4;
    // Array timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ERASE_TIME_NS = 2000;
    localparam int PROGRAM_TIME_NS = 2000;
    localparam int ERASE_CYCLES =
        (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYCLES =
        (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MODE_EE_BYTE = 2'h0,
        MODE_BLOCK_ERASE = 2'h1,
        MODE_BLOCK_PROGRAM = 2'h2
    } write_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ERASE = 2'h1,
        ST_PROGRAM = 2'h3,
        ST_DONE = 2'h2
    } engine_state_t;
endpackage : nvm_prog_pkg

// ==== hw/level_sync.sv ====
// Two-flop synchroniser for a level or toggle
`timescale 1ns/1ns
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : level_sync

// ==== test/nvm_programmer_model.sv ====
// Programmer model driving the serial programming port
`timescale 1ns/1ns
module nvm_programmer_model (
    output logic prog_serial_clock,
    output logic prog_serial_line_in,
    input wire logic prog_serial_line_out,
    input wire logic prog_serial_line_oe
);
    logic drv;
    // Device owns the shared line while it drives
    assign prog_serial_line_in =
        prog_serial_line_oe ? prog_serial_line_out : drv;
    initial
    begin
        prog_serial_clock = 1'b0;
        drv = 1'b0;
    end
    // Command LSB first, then payload LSB first
    task automatic frame(input logic [3:0] cmd, input logic [15:0] pay,
                         output logic [7:0] rd);
        logic [19:0] bits;
        bits = {pay, cmd};
        rd = 8'h00;
        // Released inverse stands a moment before the next frame
        #1;
        for (int i = 0; i < 20; i++)
        begin
            drv = bits[i];
            #2 prog_serial_clock = 1'b1;
            #3 prog_serial_clock = 1'b0;
            #1;
            // Shift-out byte sampled after falls 12 to 19
            if (i >= 11 && i <= 18)
                rd[i-11] = prog_serial_line_in;
        end
        // Clock stands low between frames; stale line shows inverse
        drv = ~drv;
    endtask : frame
endmodule : nvm_programmer_model

// ==== test/serial_nvm_write_sequencer_tb_top.sv ====
// Self-checking bench of the serial nonvolatile write sequencer
`timescale 1ns/1ns
module serial_nvm_write_sequencer_tb_top;
    import nvm_prog_pkg::*;
    logic clk_sys, rst_n, psc, pli, plo, ploe, code, erase, prog, busy;
    logic [21:0] addr, cap_addr;
    logic [7:0] nbyte, cap_byte, rd;
    logic [63:0] block, cap_block;
    logic cap_code, saw_erase, saw_prog, bad_order;
    int mismatches, checked, cycles;
    serial_nvm_write_sequencer #(.BUF_BYTES(8), .ERASE_COUNT(5),
        .PROGRAM_COUNT(5)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .prog_serial_clock(psc), .prog_serial_line_in(pli),
        .prog_serial_line_out(plo), .prog_serial_line_oe(ploe),
        .nv_addr(addr), .nv_byte(nbyte), .nv_block(block),
        .nv_code_space(code), .nv_erase_en(erase),
        .nv_program_en(prog), .write_busy(busy));
    nvm_programmer_model i_prog (.prog_serial_clock(psc),
        .prog_serial_line_in(pli), .prog_serial_line_out(plo),
        .prog_serial_line_oe(ploe));
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Engine phases are short, so they are captured as they pass
    // Falling edge, so the outputs launched on the rise have settled
    always @(negedge clk_sys)
    begin
        cycles++;
        if (erase === 1'b1)
        begin
            saw_erase = 1'b1;
            cap_addr = addr;
            cap_code = code;
        end
        if (prog === 1'b1)
        begin
            bad_order = bad_order | ~saw_erase;
            saw_prog = 1'b1;
            cap_addr = addr;
            cap_byte = nbyte;
            cap_block = block;
            cap_code = code;
        end
        if (cycles == 20000)
        begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic core(input logic [15:0] p);
        i_prog.frame(4'h0, p, rd);
    endtask : core
    task automatic start_and_finish(input logic [3:0] cmd,
                                    input logic [15:0] p);
        saw_erase = 1'b0;
        saw_prog = 1'b0;
        bad_order = 1'b0;
        i_prog.frame(cmd, p, rd);
        core(16'h0000);
        // Clock held low for array discharge
        #200;
        for (int i = 0; i < 100 && busy !== 1'b0; i++)
            @(posedge clk_sys);
        check("engine idle", busy, 1'b0);
    endtask : start_and_finish
    task automatic test_data_write();
        core(16'h9ea6);
        core(16'h9ca6);
        core(16'h0e5a);
        core(16'h6ea9);
        core(16'h0e03);
        core(16'h6eaa);
        core(16'h0ec3);
        core(16'h6ea8);
        core(16'h84a6);
        start_and_finish(4'h0, 16'h82a6);
        check("data addr", cap_addr, 22'h00035a);
        check("data byte", cap_byte, 8'hc3);
        check("code space", cap_code, 1'b0);
        check("erase seen", saw_erase, 1'b1);
        check("erase first", bad_order, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            core(16'h50a6);
            core(16'h6ef5);
            core(16'h0000);
            i_prog.frame(4'h2, 16'h0000, rd);
            if (rd[1] === 1'b0)
                break;
        end
        check("polled control", rd, 8'h04);
    endtask : test_data_write
    task automatic test_refused();
        core(16'h94a6);
        start_and_finish(4'h0, 16'h82a6);
        check("refused write", {saw_erase, saw_prog}, 2'b00);
    endtask : test_refused
    task automatic test_block();
        logic [7:0] base;
        core(16'h8ea6);
        core(16'h9ca6);
        core(16'h84a6);
        core(16'h0e00);
        core(16'h6ef8);
        core(16'h6ef7);
        // Two passes, one write buffer apart
        for (int pass = 0; pass < 2; pass++)
        begin
            base = 8'h10 + 8'(pass * WRITE_BUFFER_BYTES);
            core({8'h0e, base});
            core(16'h6ef6);
            core(16'h88a6);
            start_and_finish(4'h0, 16'h82a6);
            check("erase only", {saw_erase, saw_prog}, 2'b10);
            check("erase addr", {cap_code, cap_addr},
                  {1'b1, 14'h0000, base});
            i_prog.frame(4'hd, 16'h1100, rd);
            i_prog.frame(4'hd, 16'h3322, rd);
            i_prog.frame(4'hd, 16'h5544, rd);
            start_and_finish(4'hf, 16'h7766);
            check("block data", cap_block, 64'h7766554433221100);
            check("block addr", cap_addr, {14'h0000, base});
            check("block prog", {saw_prog, cap_code}, 2'b11);
        end
        core(16'h94a6);
    endtask : test_block
    task automatic report_and_stop();
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        rst_n = 1'b0;
        mismatches = 0;
        checked = 0;
        cycles = 0;
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        test_data_write();
        test_refused();
        test_block();
        report_and_stop();
    end
endmodule : serial_nvm_write_sequencer_tb_top
